// >>> design/vout_limits_uv_fault_response.sv
`timescale 1ns/1ps
// Functional notes
// - hold 16-bit high warning threshold, exponent -5
// - hold 16-bit low warning threshold
// - hold 16-bit low fault threshold
// - action bits 2:0 give delay in 200ms
// - response 00 keeps regulating after low fault
// - response 10 disables output, then follows retries
// - retries 000: stay off until fault cleared
// - retries 1..6 attempts, then latch off
// - attempt starts spaced by delay field units
// - retries 111 retry until commanded off
module vout_limits_uv_fault_response #(
  parameter int unsigned UNIT_CYCLES = vout_sup_pkg::DELAY_UNIT_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_cmd,
  input wire logic [15:0] i_wr_data,
  output logic [15:0] o_rd_data,
  output logic o_rd_valid,
  output logic o_cmd_error,
  input wire logic [15:0] i_vout_meas,
  input wire logic i_on_cmd,
  input wire logic i_shutdown,
  input wire logic i_fault_clear,
  output logic o_output_en,
  output vout_sup_pkg::vout_flags_t o_flags,
  output logic [2:0] o_tries,
  output logic o_latched_off
);

  // ****************************************
  // configuration registers
  // ****************************************
  logic [15:0] high_warn_q;
  logic [15:0] low_warn_q;
  logic [15:0] low_fault_q;
  vout_sup_pkg::fault_action_t action_q;
  logic known_cmd;

  assign known_cmd = (i_cmd == vout_sup_pkg::CMD_HIGH_WARN) ||
    (i_cmd == vout_sup_pkg::CMD_LOW_WARN) ||
    (i_cmd == vout_sup_pkg::CMD_LOW_FAULT) ||
    (i_cmd == vout_sup_pkg::CMD_LOW_ACTION);

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      high_warn_q <= vout_sup_pkg::HIGH_WARN_RST;
      low_warn_q <= vout_sup_pkg::LOW_WARN_RST;
      low_fault_q <= vout_sup_pkg::LOW_FAULT_RST;
      action_q <= vout_sup_pkg::LOW_ACTION_RST;
    end else if (i_wr_en) begin
      case (i_cmd)
        vout_sup_pkg::CMD_HIGH_WARN: high_warn_q <= i_wr_data;
        vout_sup_pkg::CMD_LOW_WARN: low_warn_q <= i_wr_data;
        vout_sup_pkg::CMD_LOW_FAULT: low_fault_q <= i_wr_data;
        vout_sup_pkg::CMD_LOW_ACTION: action_q <= i_wr_data[7:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // read-back
  // ****************************************
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_rd_data <= 16'h0000;
      o_rd_valid <= 1'b0;
      o_cmd_error <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_en && known_cmd;
      o_cmd_error <= (i_rd_en || i_wr_en) && !known_cmd;
      if (i_rd_en) begin
        case (i_cmd)
          vout_sup_pkg::CMD_HIGH_WARN: o_rd_data <= high_warn_q;
          vout_sup_pkg::CMD_LOW_WARN: o_rd_data <= low_warn_q;
          vout_sup_pkg::CMD_LOW_FAULT: o_rd_data <= low_fault_q;
          vout_sup_pkg::CMD_LOW_ACTION: o_rd_data <= {8'h00, action_q};
          default: o_rd_data <= 16'h0000;
        endcase
      end
    end
  end

  // ****************************************
  // voltage comparisons
  // ****************************************
  logic uv_now;

  assign uv_now = i_vout_meas < low_fault_q;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_flags <= '0;
    end else begin
      o_flags.ov_warn <= i_vout_meas > high_warn_q;
      o_flags.uv_warn <= i_vout_meas < low_warn_q;
      o_flags.uv_fault <= uv_now;
    end
  end

  // ****************************************
  // low fault response state machine
  // ****************************************
  vout_sup_pkg::uv_state_t state_q;
  vout_sup_pkg::uv_state_t state_d;
  logic [2:0] tries_d;
  logic timer_start;
  logic timer_done;
  logic tries_left;

  assign tries_left = (action_q.retries == vout_sup_pkg::RETRY_FOREVER) ||
    (o_tries != action_q.retries);

  always_comb begin
    state_d = state_q;
    tries_d = o_tries;
    timer_start = 1'b0;
    case (state_q)
      vout_sup_pkg::ST_OFF: begin
        if (i_on_cmd && !i_shutdown) begin
          state_d = vout_sup_pkg::ST_RUN;
        end
      end
      vout_sup_pkg::ST_RUN: begin
        // any response other than disable keeps regulating
        if (uv_now && action_q.resp == vout_sup_pkg::RESP_DISABLE) begin
          tries_d = 3'h0;
          if (action_q.retries == vout_sup_pkg::RETRY_NONE) begin
            state_d = vout_sup_pkg::ST_LATCH;
          end else begin
            state_d = vout_sup_pkg::ST_WAIT;
            timer_start = 1'b1;
          end
        end
      end
      vout_sup_pkg::ST_WAIT: begin
        if (timer_done) begin
          state_d = vout_sup_pkg::ST_TRY;
          tries_d = o_tries + 3'h1;
          timer_start = 1'b1;
        end
      end
      vout_sup_pkg::ST_TRY: begin
        if (timer_done) begin
          if (!uv_now) begin
            state_d = vout_sup_pkg::ST_RUN;
          end else if (tries_left) begin
            state_d = vout_sup_pkg::ST_TRY;
            tries_d = o_tries + 3'h1;
            timer_start = 1'b1;
          end else begin
            state_d = vout_sup_pkg::ST_LATCH;
          end
        end
      end
      vout_sup_pkg::ST_LATCH: begin
        if (i_fault_clear) begin
          state_d = vout_sup_pkg::ST_OFF;
        end
      end
      default: state_d = vout_sup_pkg::ST_OFF;
    endcase
    // off command wins everywhere but a latched fault
    if ((!i_on_cmd || i_shutdown) &&
        state_q != vout_sup_pkg::ST_LATCH) begin
      state_d = vout_sup_pkg::ST_OFF;
      timer_start = 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_q <= vout_sup_pkg::ST_OFF;
      o_tries <= 3'h0;
    end else begin
      state_q <= state_d;
      o_tries <= tries_d;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_output_en <= 1'b0;
      o_latched_off <= 1'b0;
    end else begin
      o_output_en <= (state_d == vout_sup_pkg::ST_RUN) ||
        (state_d == vout_sup_pkg::ST_TRY);
      o_latched_off <= state_d == vout_sup_pkg::ST_LATCH;
    end
  end

  restart_timer #(
    .UNIT_CYCLES(UNIT_CYCLES)
  ) u_timer (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_start(timer_start),
    .i_units(action_q.delay),
    .o_done(timer_done)
  );

  // ****************************************
  // checks
  // ****************************************
  a_high_warn_hold: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_wr_en && i_cmd == vout_sup_pkg::CMD_HIGH_WARN |=>
    high_warn_q == $past(i_wr_data)) else $error("high warn not stored");
  a_low_warn_hold: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_wr_en && i_cmd == vout_sup_pkg::CMD_LOW_WARN |=>
    low_warn_q == $past(i_wr_data)) else $error("low warn not stored");
  a_low_fault_hold: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_rd_en && i_cmd == vout_sup_pkg::CMD_LOW_FAULT |=>
    o_rd_valid && o_rd_data == $past(low_fault_q))
    else $error("low fault readback wrong");
  a_ignore_keeps_on: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    state_q == vout_sup_pkg::ST_RUN && uv_now && i_on_cmd && !i_shutdown &&
    action_q.resp == vout_sup_pkg::RESP_IGNORE |=> o_output_en)
    else $error("output dropped under ignore");
  a_disable_on_fault: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    state_q == vout_sup_pkg::ST_RUN && uv_now &&
    action_q.resp == vout_sup_pkg::RESP_DISABLE |=> !o_output_en)
    else $error("output not disabled");
  a_no_retry_latch: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    state_q == vout_sup_pkg::ST_RUN && uv_now && i_on_cmd && !i_shutdown &&
    action_q.resp == vout_sup_pkg::RESP_DISABLE &&
    action_q.retries == vout_sup_pkg::RETRY_NONE |=> o_latched_off ##1
    (o_latched_off || $past(i_fault_clear))) else $error("no latch");
  a_retry_limit: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    state_q == vout_sup_pkg::ST_TRY && timer_done && uv_now && i_on_cmd &&
    !i_shutdown && o_tries == action_q.retries &&
    action_q.retries != vout_sup_pkg::RETRY_FOREVER |=>
    o_latched_off && !o_output_en) else $error("retry limit missed");
  a_attempt_spacing: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    $rose(o_output_en) && state_q == vout_sup_pkg::ST_TRY |->
    $past(state_q) == vout_sup_pkg::ST_WAIT && $past(timer_done))
    else $error("attempt not timed");
  a_retry_forever: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    state_q == vout_sup_pkg::ST_TRY && timer_done && uv_now && i_on_cmd &&
    !i_shutdown && action_q.retries == vout_sup_pkg::RETRY_FOREVER |=>
    state_q == vout_sup_pkg::ST_TRY && o_output_en)
    else $error("endless retry stopped");
  a_ov_warn_flag: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    ##1 o_flags.ov_warn == ($past(i_vout_meas) > $past(high_warn_q)))
    else $error("ov warn flag wrong");

endmodule

// >>> shared/vout_sup_pkg.sv
package vout_sup_pkg;

  // ****************************************
  // clock and restart timing
  // ****************************************
  localparam int unsigned CLOCK_HZ = 125000000;
  localparam int unsigned HZ_PER_KHZ = 1000;
  localparam int unsigned DELAY_UNIT_MS = 200;
  localparam int unsigned DELAY_UNIT_CYCLES =
    (CLOCK_HZ / HZ_PER_KHZ) * DELAY_UNIT_MS;

  // ****************************************
  // command codes
  // ****************************************
  localparam logic [7:0] CMD_HIGH_WARN = 8'h42;
  localparam logic [7:0] CMD_LOW_WARN = 8'h43;
  localparam logic [7:0] CMD_LOW_FAULT = 8'h44;
  localparam logic [7:0] CMD_LOW_ACTION = 8'h45;

  // ****************************************
  // data format and field codes
  // ****************************************
  localparam int VOUT_EXPONENT = -5;
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_DISABLE = 2'h2;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  localparam logic [2:0] UNITS_MIN = 3'h1;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] HIGH_WARN_RST = 16'hffff;
  localparam logic [15:0] LOW_WARN_RST = 16'h0000;
  localparam logic [15:0] LOW_FAULT_RST = 16'h0000;
  localparam logic [7:0] LOW_ACTION_RST = 8'h00;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [1:0] resp;
    logic [2:0] retries;
    logic [2:0] delay;
  } fault_action_t;

  typedef struct packed {
    logic ov_warn;
    logic uv_warn;
    logic uv_fault;
  } vout_flags_t;

  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_RUN = 3'h1,
    ST_WAIT = 3'h3,
    ST_TRY = 3'h2,
    ST_LATCH = 3'h6
  } uv_state_t;

endpackage

// >>> design/restart_timer.sv
`timescale 1ns/1ps
module restart_timer #(
  parameter int unsigned UNIT_CYCLES = vout_sup_pkg::DELAY_UNIT_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_start,
  input wire logic [2:0] i_units,
  output logic o_done
);

  // ****************************************
  // unit prescaler and unit countdown
  // ****************************************
  logic [31:0] pre_q;
  logic [2:0] left_q;
  logic busy_q;
  logic tick;

  assign tick = busy_q && (pre_q == 32'(UNIT_CYCLES - 1));

  always_ff @(posedge i_clock) begin
    if (i_sys_rst || i_start || tick) begin
      pre_q <= 32'h0000_0000;
    end else if (busy_q) begin
      pre_q <= pre_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      busy_q <= 1'b0;
      left_q <= 3'h0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        busy_q <= 1'b1;
        // zero units still waits one unit
        left_q <= (i_units == 3'h0) ? vout_sup_pkg::UNITS_MIN : i_units;
      end else if (tick) begin
        if (left_q == vout_sup_pkg::UNITS_MIN) begin
          busy_q <= 1'b0;
          o_done <= 1'b1;
        end
        left_q <= left_q - 3'h1;
      end
    end
  end

endmodule

// >>> testbench/host_model.sv
`timescale 1ns/1ps
module host_model (
  input wire logic i_clock,
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [7:0] o_cmd,
  output logic [15:0] o_wr_data,
  input wire logic [15:0] i_rd_data,
  input wire logic i_rd_valid,
  input wire logic i_cmd_error
);
  // ****
  // command strobes, one word per access
  // ****
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_cmd = 8'h00;
    o_wr_data = 16'h0000;
  end

  // wait for the taking edge, the answer stands just after it
  task automatic take();
    @(posedge i_clock);
    #1;
  endtask

  // released lines are scrambled, not left at the last value;
  // one idle edge passes before the next access
  task automatic idle();
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_cmd = ~o_cmd;
    o_wr_data = ~o_wr_data;
    @(posedge i_clock);
    #1;
  endtask

  task automatic wr(input logic [7:0] c, input logic [15:0] w,
                    output logic e);
    o_wr_en = 1'b1;
    o_cmd = c;
    o_wr_data = w;
    take();
    e = i_cmd_error;
    idle();
  endtask

  task automatic rd(input logic [7:0] c, output logic [15:0] d,
                    output logic v, output logic e);
    o_rd_en = 1'b1;
    o_cmd = c;
    take();
    d = i_rd_data;
    v = i_rd_valid;
    e = i_cmd_error;
    idle();
  endtask
endmodule

// >>> testbench/tb_vout_limits_uv_fault_response.sv
`timescale 1ns/1ps
module tb_vout_limits_uv_fault_response;
  localparam int unsigned UNITS = 4;
  logic clock, sys_rst, wr_en, rd_en, on_cmd, shutdown, fault_clear;
  logic rd_valid, cmd_error, output_en, latched_off, v, e;
  logic [7:0] cmd;
  logic [15:0] wr_data, rd_data, meas, d;
  logic [2:0] tries;
  vout_sup_pkg::vout_flags_t flags;
  int num_errors = 0;
  int checked = 0;
  int n;
  typedef struct {
    logic [7:0] c;
    logic [15:0] w, r, m;
    logic [2:0] f;
  } row_t;
  row_t rows [5] = '{'{8'h42, 16'h8300, 16'h8300, 16'h8350, 3'h4},
                     '{8'h43, 16'h4200, 16'h4200, 16'h4150, 3'h2},
                     '{8'h44, 16'h2100, 16'h2100, 16'h2050, 3'h3},
                     '{8'h45, 16'hff00, 16'h0000, 16'h2100, 3'h2},
                     '{8'h45, 16'h003f, 16'h003f, 16'h8300, 3'h0}};
  logic [15:0] rst_exp [4] = '{16'hffff, 16'h0000, 16'h0000, 16'h0000};

  vout_limits_uv_fault_response #(.UNIT_CYCLES(UNITS)) uut (
    .i_clock(clock), .i_sys_rst(sys_rst), .i_wr_en(wr_en),
    .i_rd_en(rd_en), .i_cmd(cmd), .i_wr_data(wr_data),
    .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_cmd_error(cmd_error),
    .i_vout_meas(meas), .i_on_cmd(on_cmd), .i_shutdown(shutdown),
    .i_fault_clear(fault_clear), .o_output_en(output_en),
    .o_flags(flags), .o_tries(tries), .o_latched_off(latched_off));

  host_model host (
    .i_clock(clock), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_cmd(cmd),
    .o_wr_data(wr_data), .i_rd_data(rd_data), .i_rd_valid(rd_valid),
    .i_cmd_error(cmd_error));

  // ****
  // helpers
  // ****
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic summarize();
    if (num_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] ex, got);
    checked++;
    if (got !== ex) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  // sel 0: output enable, 1: latched off, 2: attempt count
  task automatic wait_for(input int sel, input logic [2:0] lvl,
                          output int c);
    c = 0;
    while ((sel == 0 ? {2'h0, output_en} : sel == 1 ?
            {2'h0, latched_off} : tries) !== lvl && c < 200) begin
      tick(1);
      c++;
    end
    if (c >= 200) begin
      chk("wait", 16'h0, 16'h1);
      summarize();
    end
  endtask

  task automatic act(input logic [15:0] w);
    host.wr(vout_sup_pkg::CMD_LOW_ACTION, w, e);
    meas = 16'h0050;
  endtask

  task automatic recover();
    meas = 16'h4250;
    on_cmd = 1'b1;
    fault_clear = 1'b1;
    tick(1);
    fault_clear = 1'b0;
    wait_for(0, 3'h1, n);
  endtask

  // ****
  // main sequence
  // ****
  initial begin
    sys_rst = 1'b1;
    on_cmd = 1'b1;
    shutdown = 1'b0;
    fault_clear = 1'b0;
    meas = 16'h4250;
    tick(4);
    sys_rst = 1'b0;
    tick(2);
    foreach (rows[i]) begin
      host.wr(rows[i].c, rows[i].w, e);
      chk("wr_err", 16'h0, {15'h0, e});
      host.rd(rows[i].c, d, v, e);
      chk("rd_data", rows[i].r, d);
      chk("rd_valid", 16'h1, {15'h0, v});
      meas = rows[i].m;
      tick(1);
      chk("flags", {13'h0, rows[i].f}, {13'h0, flags});
      chk("out_en", 16'h1, {15'h0, output_en});
    end
    host.wr(8'h46, 16'h5555, e);
    chk("wr_err", 16'h1, {15'h0, e});
    host.rd(8'h46, d, v, e);
    chk("rd_bad", 16'h0, d);
    chk("rd_bad_flags", 16'h1, {14'h0, v, e});
    act(16'h0092);
    wait_for(0, 3'h0, n);
    chk("off_lat", 16'h1, {15'h0, n <= 2});
    wait_for(2, 3'h1, n);
    chk("on_try", 16'h1, {15'h0, output_en});
    wait_for(2, 3'h2, n);
    chk("spacing", 16'h1, {15'h0, n >= 2 * UNITS && n <= 2 * UNITS + 2});
    wait_for(1, 3'h1, n);
    chk("tries", 16'h2, {13'h0, tries});
    chk("out_en", 16'h0, {15'h0, output_en});
    on_cmd = 1'b0;
    tick(3);
    chk("latched", 16'h1, {15'h0, latched_off});
    recover();
    act(16'h0080);
    wait_for(1, 3'h1, n);
    chk("no_retry", 16'h1, {15'h0, n <= 3 && tries === 3'h0});
    chk("out_en", 16'h0, {15'h0, output_en});
    recover();
    act(16'h00b9);
    wait_for(2, 3'h7, n);
    chk("forever", 16'h0, {15'h0, latched_off});
    on_cmd = 1'b0;
    wait_for(0, 3'h0, n);
    chk("cmd_off", 16'h1, {15'h0, n <= 2});
    recover();
    shutdown = 1'b1;
    wait_for(0, 3'h0, n);
    chk("shut_off", 16'h1, {15'h0, n <= 2});
    shutdown = 1'b0;
    sys_rst = 1'b1;
    tick(2);
    sys_rst = 1'b0;
    chk("rst_out", 16'h0, {15'h0, output_en});
    foreach (rst_exp[i]) begin
      host.rd(8'h42 + 8'(i), d, v, e);
      chk("rst_val", rst_exp[i], d);
    end
    summarize();
  end
endmodule
